// >>> rtl/uemr_responder.sv
// endpoint token responder with upstream pin forcing and wishbone registers
`timescale 1ns/100ps
`default_nettype none

module uemr_responder
	import uemr_pkg::*;
#(
	parameter int EP_COUNT = UEMR_EP_COUNT
) (
	input  wire logic                     clk_sys,
	input  wire logic                     rst,
	// wishbone classic slave
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [7:0]               wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [31:0]              wb_dat_i,
	output logic      [31:0]              wb_dat_o,
	output logic                          wb_ack_o,
	// token from the protocol engine
	input  wire logic                     tokValid,
	input  wire uemr_pkg::uemr_tok_t      tokKind,
	input  wire logic [UEMR_EP_IDX_W-1:0] tokEp,
	input  wire logic                     tokCtrlEp,
	input  wire logic                     pktValid,
	input  wire logic                     pktZeroLen,
	input  wire logic                     dataToggleBit,
	input  wire logic                     hostAcked,
	// answer to the protocol engine
	output logic                          ansValid,
	output uemr_pkg::uemr_ans_t           ansCode,
	output logic      [3:0]               ansCount,
	// upstream pair from the engine and to the pads
	input  wire logic                     engDpOut,
	input  wire logic                     engDmOut,
	input  wire logic                     engOe,
	input  wire logic                     usbDpIn,
	input  wire logic                     usbDmIn,
	output logic                          usbDpOut,
	output logic                          usbDpOe,
	output logic                          usbDmOut,
	output logic                          usbDmOe
);
	import uemr_pkg::*;

	// endpoint index is only UEMR_EP_IDX_W bits wide
	if (EP_COUNT < 1 || EP_COUNT > (1 << UEMR_EP_IDX_W)) begin : g_bad_count
		$error("EP_COUNT out of range");
	end

	logic [2:0]  ctrlAct_r;
	logic [3:0]  epMode_r  [EP_COUNT];
	logic        epStall_r [EP_COUNT];
	logic [3:0]  epCount_r [EP_COUNT];
	logic        pendRewrite_r;
	logic [UEMR_EP_IDX_W-1:0] pendEp_r;
	logic [3:0]  pendMode_r;

	////////////////////////////////////////////////////////////////////////////////
	// bus decode

	logic        wbReq;
	logic        wbWr;
	logic        hitCtrl;
	logic        hitMode;
	logic        hitCount;
	logic [UEMR_EP_IDX_W-1:0] regEp;

	function automatic logic epHit(input logic [7:0] adr, input logic [7:0] base);
		logic [7:0] top;
		top = 8'(base + 8'(EP_COUNT * 4));
		return (adr >= base) && (adr < top) && (adr[1:0] == 2'h0);
	endfunction

	assign wbReq    = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wbWr     = wbReq && wb_we_i && wb_sel_i[0];
	assign hitCtrl  = wb_adr_i == OFF_USB_CTRL;
	assign hitMode  = epHit(wb_adr_i, OFF_EP_MODE);
	assign hitCount = epHit(wb_adr_i, OFF_EP_COUNT);
	assign regEp    = wb_adr_i[2 +: UEMR_EP_IDX_W];

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wbReq;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wbReq) begin
			wb_dat_o <= 32'h0000_0000;
			if (hitCtrl) begin
				wb_dat_o[CTRL_ACT_MSB:CTRL_ACT_LSB] <= ctrlAct_r;
				wb_dat_o[CTRL_DP_BIT] <= usbDpIn;
				wb_dat_o[CTRL_DM_BIT] <= usbDmIn;
			end else if (hitMode) begin
				wb_dat_o[MODE_MSB:MODE_LSB] <= epMode_r[regEp];
				wb_dat_o[MODE_STALL_BIT] <= epStall_r[regEp];
			end else if (hitCount) begin
				wb_dat_o[CNT_MSB:CNT_LSB] <= epCount_r[regEp];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// upstream forcing

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrlAct_r <= CTRL_RESET;
		end else if (wbWr && hitCtrl) begin
			ctrlAct_r <= wb_dat_i[CTRL_ACT_MSB:CTRL_ACT_LSB];
		end
	end

	always_comb begin
		usbDpOut = 1'b0;
		usbDmOut = 1'b0;
		usbDpOe  = 1'b1;
		usbDmOe  = 1'b1;
		case (ctrlAct_r)
			ACT_NONE: begin
				usbDpOut = engDpOut;
				usbDmOut = engDmOut;
				usbDpOe  = engOe;
				usbDmOe  = engOe;
			end
			ACT_J: usbDpOut = 1'b1;
			ACT_K: usbDmOut = 1'b1;
			ACT_SE0, ACT_LOWLOW: begin
			end
			ACT_ZLOW: usbDpOe = 1'b0;
			ACT_LOWZ: usbDmOe = 1'b0;
			ACT_ZZ: begin
				usbDpOe = 1'b0;
				usbDmOe = 1'b0;
			end
			default: begin
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// token decode

	logic [3:0] curMode;
	logic       curStall;
	uemr_ans_t  decAns;
	logic       outOk;

	assign curMode  = epMode_r[tokEp];
	assign curStall = epStall_r[tokEp];
	assign outOk    = pktValid && pktZeroLen && dataToggleBit;

	// failed check stalls a valid packet, ignores a bad one
	function automatic uemr_ans_t checkOut(input logic ok, input logic valid);
		if (ok)
			return ANS_ACK;
		return valid ? ANS_STALL : ANS_IGNORE;
	endfunction

	always_comb begin
		decAns = ANS_IGNORE;
		case (tokKind)
			TOK_SETUP: begin
				case (curMode)
					M_NAK_IO, M_STAT_OUT, M_STALL_IO, M_IGN_IO, M_STAT_IN,
					M_NAK_OUT_SI, M_ACK_OUT_SI, M_NAK_IN_SO, M_ACK_IN_SO:
						decAns = pktValid ? ANS_ACK : ANS_IGNORE;
					default: decAns = ANS_IGNORE;
				endcase
			end
			TOK_IN: begin
				case (curMode)
					M_NAK_IO, M_NAK_IN, M_NAK_IN_SO: decAns = ANS_NAK;
					M_STAT_OUT, M_STALL_IO: decAns = ANS_STALL;
					M_STAT_IN, M_NAK_OUT_SI, M_ACK_OUT_SI: decAns = ANS_TX_ZERO;
					M_ISO_IN, M_ACK_IN_SO: decAns = ANS_TX_COUNT;
					M_ACK_IN: decAns = curStall ? ANS_STALL : ANS_TX_COUNT;
					default: decAns = ANS_IGNORE;
				endcase
			end
			TOK_OUT: begin
				case (curMode)
					M_NAK_IO, M_NAK_OUT, M_NAK_OUT_SI: decAns = ANS_NAK;
					M_STALL_IO, M_STAT_IN: decAns = ANS_STALL;
					M_STAT_OUT, M_NAK_IN_SO, M_ACK_IN_SO:
						decAns = checkOut(outOk, pktValid);
					M_ISO_OUT: decAns = ANS_ACK;
					M_ACK_OUT: decAns = curStall ? ANS_STALL : ANS_ACK;
					M_ACK_OUT_SI: decAns = ANS_ACK;
					default: decAns = ANS_IGNORE;
				endcase
			end
			default: decAns = ANS_IGNORE;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ansValid <= 1'b0;
			ansCode  <= ANS_IGNORE;
			ansCount <= COUNT_RESET;
		end else begin
			ansValid <= tokValid && decAns != ANS_IGNORE;
			ansCode  <= tokValid ? decAns : ANS_IGNORE;
			ansCount <= (tokValid && decAns == ANS_TX_COUNT) ? epCount_r[tokEp] : 4'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// automatic mode rewrite after handshake

	function automatic logic [3:0] afterAck(input logic [3:0] m);
		case (m)
			M_ACK_OUT:    return M_NAK_OUT;
			M_ACK_OUT_SI: return M_NAK_OUT_SI;
			M_ACK_IN:     return M_NAK_IN;
			M_ACK_IN_SO:  return M_NAK_IN_SO;
			default:      return m;
		endcase
	endfunction

	logic tokIsSetupForce;
	logic ackArms;

	assign tokIsSetupForce = tokValid && tokKind == TOK_SETUP && tokCtrlEp
		&& curMode != M_DISABLE;
	assign ackArms = tokValid && afterAck(curMode) != curMode && !curStall
		&& ((tokKind == TOK_OUT && decAns == ANS_ACK)
		|| (tokKind == TOK_IN && decAns == ANS_TX_COUNT));

	// in-mode rewrite waits for the host ACK of the data packet
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pendRewrite_r <= 1'b0;
			pendEp_r      <= '0;
			pendMode_r    <= MODE_RESET;
		end else if (ackArms && tokKind == TOK_IN) begin
			pendRewrite_r <= 1'b1;
			pendEp_r      <= tokEp;
			pendMode_r    <= afterAck(curMode);
		end else if (hostAcked || tokValid) begin
			pendRewrite_r <= 1'b0;
		end
	end

	// mode nibble, hardware rewrite wins over a same-cycle bus write
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < EP_COUNT; i++) begin
				epMode_r[i]  <= MODE_RESET;
				epStall_r[i] <= 1'b0;
				epCount_r[i] <= COUNT_RESET;
			end
		end else begin
			if (wbWr && hitMode) begin
				epMode_r[regEp]  <= wb_dat_i[MODE_MSB:MODE_LSB];
				epStall_r[regEp] <= wb_dat_i[MODE_STALL_BIT];
			end
			if (wbWr && hitCount)
				epCount_r[regEp] <= wb_dat_i[CNT_MSB:CNT_LSB];
			if (pendRewrite_r && hostAcked && !tokValid)
				epMode_r[pendEp_r] <= pendMode_r;
			if (tokIsSetupForce)
				epMode_r[tokEp] <= M_NAK_IO;
			else if (ackArms && tokKind == TOK_OUT)
				epMode_r[tokEp] <= afterAck(curMode);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	chk_disable_silent: assert property (@(posedge clk_sys) disable iff (rst)
		tokValid && curMode == M_DISABLE |=> !ansValid)
		else $error("disabled endpoint answered");
	chk_nak_io_setup: assert property (@(posedge clk_sys) disable iff (rst)
		tokValid && tokKind == TOK_SETUP && pktValid && curMode == M_NAK_IO
		|=> ansValid && ansCode == ANS_ACK)
		else $error("nak mode did not ack setup");
	chk_setup_force: assert property (@(posedge clk_sys) disable iff (rst)
		tokIsSetupForce |=> epMode_r[$past(tokEp)] == M_NAK_IO)
		else $error("setup did not force nak mode");
	chk_check_ack: assert property (@(posedge clk_sys) disable iff (rst)
		tokValid && tokKind == TOK_OUT && curMode == M_ACK_IN_SO && !outOk
		|=> ansCode != ANS_ACK)
		else $error("check acked a bad out");
	chk_count_sent: assert property (@(posedge clk_sys) disable iff (rst)
		tokValid && tokKind == TOK_IN && curMode == M_ISO_IN
		|=> ansCode == ANS_TX_COUNT && ansCount == $past(epCount_r[tokEp]))
		else $error("count not transmitted");
	chk_ack_out_rewrite: assert property (@(posedge clk_sys) disable iff (rst)
		tokValid && tokKind == TOK_OUT && curMode == M_ACK_OUT && !curStall
		&& !(wbWr && hitMode) |=> epMode_r[$past(tokEp)] == M_NAK_OUT)
		else $error("ack out not rewritten");
	chk_stall_in: assert property (@(posedge clk_sys) disable iff (rst)
		tokValid && tokKind == TOK_IN && curMode == M_ACK_IN && curStall
		|=> ansCode == ANS_STALL)
		else $error("stall bit ignored");
	chk_force_se0: assert property (@(posedge clk_sys) disable iff (rst)
		ctrlAct_r == ACT_SE0 |-> usbDpOe && usbDmOe && !usbDpOut && !usbDmOut)
		else $error("se0 not forced");
	chk_float_both: assert property (@(posedge clk_sys) disable iff (rst)
		ctrlAct_r == ACT_ZZ |-> !usbDpOe && !usbDmOe)
		else $error("lines not floated");

	cov_setup_force: cover property (@(posedge clk_sys) disable iff (rst) tokIsSetupForce);
	cov_in_rewrite: cover property (@(posedge clk_sys) disable iff (rst)
		pendRewrite_r && hostAcked);
	cov_check_stall: cover property (@(posedge clk_sys) disable iff (rst)
		ansValid && ansCode == ANS_STALL);

endmodule

`default_nettype wire

// >>> inc/uemr_pkg.sv
// package: register map, mode codes and answer codes of the endpoint responder
package uemr_pkg;

	localparam int UEMR_EP_COUNT   = 4;
	localparam int UEMR_EP_IDX_W   = 2;

	// wishbone word offsets (byte addresses)
	localparam logic [7:0] OFF_USB_CTRL = 8'h00;
	localparam logic [7:0] OFF_EP_MODE  = 8'h10;
	localparam logic [7:0] OFF_EP_COUNT = 8'h20;
	localparam logic [7:0] OFF_EP_STEP  = 8'h04;

	// field positions
	localparam int CTRL_ACT_LSB   = 0;
	localparam int CTRL_ACT_MSB   = 2;
	localparam int CTRL_DP_BIT    = 5;
	localparam int CTRL_DM_BIT    = 4;
	localparam int MODE_LSB       = 0;
	localparam int MODE_MSB       = 3;
	localparam int MODE_STALL_BIT = 7;
	localparam int CNT_LSB        = 0;
	localparam int CNT_MSB        = 3;

	localparam logic [2:0] CTRL_RESET  = 3'h0;
	localparam logic [3:0] MODE_RESET  = 4'h0;
	localparam logic [3:0] COUNT_RESET = 4'h0;

	// control actions on the upstream pair
	localparam logic [2:0] ACT_NONE    = 3'h0;
	localparam logic [2:0] ACT_J       = 3'h1;
	localparam logic [2:0] ACT_K       = 3'h2;
	localparam logic [2:0] ACT_SE0     = 3'h3;
	localparam logic [2:0] ACT_LOWLOW  = 3'h4;
	localparam logic [2:0] ACT_ZLOW    = 3'h5;
	localparam logic [2:0] ACT_LOWZ    = 3'h6;
	localparam logic [2:0] ACT_ZZ      = 3'h7;

	// endpoint modes
	localparam logic [3:0] M_DISABLE    = 4'h0;
	localparam logic [3:0] M_NAK_IO     = 4'h1;
	localparam logic [3:0] M_STAT_OUT   = 4'h2;
	localparam logic [3:0] M_STALL_IO   = 4'h3;
	localparam logic [3:0] M_IGN_IO     = 4'h4;
	localparam logic [3:0] M_ISO_OUT    = 4'h5;
	localparam logic [3:0] M_STAT_IN    = 4'h6;
	localparam logic [3:0] M_ISO_IN     = 4'h7;
	localparam logic [3:0] M_NAK_OUT    = 4'h8;
	localparam logic [3:0] M_ACK_OUT    = 4'h9;
	localparam logic [3:0] M_NAK_OUT_SI = 4'hA;
	localparam logic [3:0] M_ACK_OUT_SI = 4'hB;
	localparam logic [3:0] M_NAK_IN     = 4'hC;
	localparam logic [3:0] M_ACK_IN     = 4'hD;
	localparam logic [3:0] M_NAK_IN_SO  = 4'hE;
	localparam logic [3:0] M_ACK_IN_SO  = 4'hF;

	typedef enum logic [1:0] {TOK_SETUP, TOK_IN, TOK_OUT, TOK_NONE} uemr_tok_t;
	typedef enum logic [2:0] {
		ANS_IGNORE, ANS_ACK, ANS_NAK, ANS_STALL, ANS_TX_COUNT, ANS_TX_ZERO
	} uemr_ans_t;

endpackage

// >>> verif/uemr_host_model.sv
// host side model: sends tokens, records answers and acknowledges data
`timescale 1ns/100ps
`default_nettype none
module uemr_host_model
	import uemr_pkg::*;
(
	input  wire logic                clk_sys,
	input  wire logic                ansValid,
	input  wire uemr_pkg::uemr_ans_t ansCode,
	input  wire logic [3:0]          ansCount,
	output logic                     tokValid,
	output uemr_pkg::uemr_tok_t      tokKind,
	output logic [1:0]               tokEp,
	output logic                     tokCtrlEp,
	output logic                     pktValid,
	output logic                     pktZeroLen,
	output logic                     dataToggleBit,
	output logic                     hostAcked,
	output logic [7:0]               answer
);
	initial begin
		tokValid = 1'b0;
		tokKind = TOK_NONE;
		{tokEp, tokCtrlEp, pktValid, pktZeroLen, dataToggleBit, hostAcked} = '0;
		answer = 8'h00;
	end
	////////////////////////////////////////////////////////////////
	// one token per call; the answer is registered on the taking edge and read 1 ns after it
	task automatic send(input uemr_tok_t k, input logic [1:0] ep, input logic c, v, z, t);
		@(posedge clk_sys);
		tokValid <= 1'b1;
		tokKind <= k;
		{tokEp, tokCtrlEp, pktValid, pktZeroLen, dataToggleBit} <= {ep, c, v, z, t};
		@(posedge clk_sys);
		tokValid <= 1'b0;
		tokKind <= TOK_NONE;
		// stale fields inverted so a late sample cannot pass by luck
		{tokEp, tokCtrlEp, pktValid, pktZeroLen, dataToggleBit} <= ~{ep, c, v, z, t};
		#1 answer = {ansValid, ansCode, ansCount};
	endtask
	// host acknowledges our data, after a chosen delay
	task automatic pulseAck(input int gap);
		repeat (gap) @(posedge clk_sys);
		@(posedge clk_sys);
		hostAcked <= 1'b1;
		@(posedge clk_sys);
		hostAcked <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> verif/tb.sv
// testbench: register, pad forcing and token answer checks
`timescale 1ns/100ps
`default_nettype none
module tb;
	import uemr_pkg::*;
	// answer nibble per mode, mode 15 first: setup, in, out
	localparam logic [63:0] EXP [3] = '{64'h1100_1100_0101_1110,
		64'h4242_5500_4500_3320, 64'h1100_1212_0310_3120};
	localparam logic [31:0] PAD_EXP = 32'h082A_ABEE;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        wbCyc, wbStb, wbWe, wbAck;
	logic [7:0]  wbAdr;
	logic [3:0]  wbSel;
	logic [31:0] wbDatI, wbDatO, scratch;
	logic        tokValid, tokCtrlEp, pktValid, pktZeroLen, dataToggleBit, hostAcked;
	uemr_tok_t   tokKind;
	logic [1:0]  tokEp;
	logic        ansValid;
	uemr_ans_t   ansCode;
	logic [3:0]  ansCount;
	logic [7:0]  answer;
	logic        engDpOut, engDmOut, engOe, usbDpIn, usbDmIn;
	logic        usbDpOut, usbDpOe, usbDmOut, usbDmOe;
	int          failures, checkCount;
	always #5 clk_sys = ~clk_sys;
	uemr_responder #(.EP_COUNT(4)) u_uemr_responder (.clk_sys(clk_sys), .rst(rst),
		.wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
		.wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
		.tokValid(tokValid), .tokKind(tokKind), .tokEp(tokEp), .tokCtrlEp(tokCtrlEp),
		.pktValid(pktValid), .pktZeroLen(pktZeroLen), .dataToggleBit(dataToggleBit),
		.hostAcked(hostAcked), .ansValid(ansValid), .ansCode(ansCode),
		.ansCount(ansCount), .engDpOut(engDpOut), .engDmOut(engDmOut), .engOe(engOe),
		.usbDpIn(usbDpIn), .usbDmIn(usbDmIn), .usbDpOut(usbDpOut), .usbDpOe(usbDpOe),
		.usbDmOut(usbDmOut), .usbDmOe(usbDmOe));
	uemr_host_model u_uemr_host_model (.clk_sys(clk_sys), .ansValid(ansValid),
		.ansCode(ansCode), .ansCount(ansCount), .tokValid(tokValid), .tokKind(tokKind),
		.tokEp(tokEp), .tokCtrlEp(tokCtrlEp), .pktValid(pktValid),
		.pktZeroLen(pktZeroLen), .dataToggleBit(dataToggleBit), .hostAcked(hostAcked),
		.answer(answer));
	////////////////////////////////////////////////////////////////
	task automatic close_out;
		$display("checks %0d mismatches %0d", checkCount, failures);
		if (failures == 0 && checkCount > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one classic cycle; request held until the edge that sees ack
	task automatic wbXfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge clk_sys);
		{wbCyc, wbStb, wbWe, wbAdr, wbDatI, wbSel} <= {2'b11, w, a, d, 4'hF};
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (wbAck !== 1'b1 && n < 50);
		if (wbAck !== 1'b1) begin
			failures++;
			$display("Error at %0t: ack %h expected %h", $time, wbAck, 1'b1);
		end
		q = wbDatO;
		{wbCyc, wbStb, wbWe} <= 3'b000;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wbXfer(1'b1, a, d, scratch);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wbXfer(1'b0, a, 32'h0, scratch);
		chk(scratch, e);
	endtask
	function automatic logic [7:0] mAdr(input int ep);
		return 8'(OFF_EP_MODE + OFF_EP_STEP * ep);
	endfunction
	function automatic logic [7:0] ans(input uemr_ans_t c, input logic [3:0] n);
		return {c != ANS_IGNORE, c, n};
	endfunction
	task automatic tok(input int k, input logic [1:0] ep, input logic c, v, z, t,
		input logic [7:0] e);
		u_uemr_host_model.send(uemr_tok_t'(k), ep, c, v, z, t);
		chk(32'(answer), 32'(e));
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_regs;
		for (int ep = 0; ep < 4; ep++)
			rd(mAdr(ep), 32'h0);
		rd(OFF_USB_CTRL, 32'h20);
		wr(8'h30, 32'hFF);
		rd(8'h30, 32'h0);
		wr(mAdr(3), 32'hFF);
		rd(mAdr(3), 32'h8F);
		wr(OFF_EP_COUNT + 8'h0C, 32'hFF);
		rd(OFF_EP_COUNT + 8'h0C, 32'h0F);
		wr(mAdr(3), 32'h0);
		$display("register test done");
	endtask
	task automatic t_pads;
		for (int a = 0; a < 8; a++) begin
			usbDpIn <= (a < 4);
			usbDmIn <= (a >= 4);
			wr(OFF_USB_CTRL, 32'(a));
			@(posedge clk_sys);
			#1 chk({usbDpOe, usbDpOe & usbDpOut, usbDmOe, usbDmOe & usbDmOut}, PAD_EXP[4*a +: 4]);
			rd(OFF_USB_CTRL, (a < 4 ? 32'h20 : 32'h10) | 32'(a));
		end
		wr(OFF_USB_CTRL, 32'h0);
		// engine values differ from the first pass, so a fixed drive cannot pass
		{engDpOut, engDmOut, engOe} <= 3'b011;
		@(posedge clk_sys);
		#1 chk({usbDpOe, usbDpOe & usbDpOut, usbDmOe, usbDmOe & usbDmOut}, 32'hB);
		$display("pad test done");
	endtask
	task automatic t_table;
		logic [3:0] e;
		wr(OFF_EP_COUNT + 8'h04, 32'hA);
		for (int m = 0; m < 16; m++)
			for (int k = 0; k < 3; k++) begin
				e = EXP[k][4*m +: 4];
				wr(mAdr(1), 32'(m));
				tok(k, 2'd1, 1'b0, 1'b1, 1'b1, 1'b1, {e != 0, e[2:0], e == 4 ? 4'hA : 4'h0});
			end
		$display("mode table test done");
	endtask
	task automatic t_rewrite;
		wr(OFF_EP_COUNT + 8'h08, 32'h3);
		wr(mAdr(2), 32'h9);
		tok(2, 2'd2, 1'b1, 1'b1, 1'b1, 1'b1, ans(ANS_ACK, 4'h0));
		rd(mAdr(2), 32'h8);
		wr(mAdr(2), 32'hB);
		tok(2, 2'd2, 1'b1, 1'b1, 1'b1, 1'b1, ans(ANS_ACK, 4'h0));
		rd(mAdr(2), 32'hA);
		wr(mAdr(2), 32'h3);
		tok(0, 2'd2, 1'b1, 1'b1, 1'b0, 1'b0, ans(ANS_ACK, 4'h0));
		rd(mAdr(2), 32'h1);
		wr(mAdr(2), 32'hF);
		tok(2, 2'd2, 1'b1, 1'b1, 1'b0, 1'b1, ans(ANS_STALL, 4'h0));
		tok(2, 2'd2, 1'b1, 1'b1, 1'b1, 1'b0, ans(ANS_STALL, 4'h0));
		tok(2, 2'd2, 1'b1, 1'b0, 1'b1, 1'b1, ans(ANS_IGNORE, 4'h0));
		wr(mAdr(2), 32'h89);
		tok(2, 2'd2, 1'b0, 1'b1, 1'b1, 1'b1, ans(ANS_STALL, 4'h0));
		wr(mAdr(2), 32'h8D);
		tok(1, 2'd2, 1'b0, 1'b1, 1'b1, 1'b1, ans(ANS_STALL, 4'h0));
		wr(mAdr(2), 32'hD);
		tok(1, 2'd2, 1'b0, 1'b1, 1'b1, 1'b1, ans(ANS_TX_COUNT, 4'h3));
		u_uemr_host_model.pulseAck(3);
		rd(mAdr(2), 32'hC);
		wr(mAdr(2), 32'hD);
		tok(1, 2'd2, 1'b0, 1'b1, 1'b1, 1'b1, ans(ANS_TX_COUNT, 4'h3));
		// a new token drops the pending rewrite, so the late host ack changes nothing
		tok(2, 2'd2, 1'b0, 1'b1, 1'b1, 1'b1, ans(ANS_IGNORE, 4'h0));
		u_uemr_host_model.pulseAck(0);
		rd(mAdr(2), 32'hD);
		wr(mAdr(2), 32'hF);
		tok(1, 2'd2, 1'b1, 1'b1, 1'b1, 1'b1, ans(ANS_TX_COUNT, 4'h3));
		u_uemr_host_model.pulseAck(0);
		rd(mAdr(2), 32'hE);
		$display("rewrite test done");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		failures = 0;
		checkCount = 0;
		{wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} = '0;
		{engDpOut, engDmOut, engOe, usbDpIn, usbDmIn} = 5'b10110;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		t_regs;
		t_pads;
		t_table;
		t_rewrite;
		close_out;
	end
	// whole run is a few hundred cycles; this allows ten thousand
	initial begin
		#100000;
		failures++;
		$display("Error at %0t: watchdog expired", $time);
		close_out;
	end
endmodule
`default_nettype wire
